// >>> core/evpd_consts.svh
// Offsets, vector codes and reset values of the exception vector decoder
`ifndef EVPD_CONSTS_SVH
`define EVPD_CONSTS_SVH

// ----------------------------------------------------------------------
// Register map (byte addresses on the register bus)
// ----------------------------------------------------------------------
`define EVPD_OFS_BASE 4'h0
`define EVPD_OFS_STAT 4'h4
`define EVPD_ADR_W 4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define EVPD_BASE_RST 8'hFF
`define EVPD_VEC_RST 16'h0000

// ----------------------------------------------------------------------
// Fixed reset vectors
// ----------------------------------------------------------------------
`define EVPD_VEC_PIN_RST 16'hFFFE
`define EVPD_VEC_CLKMON_RST 16'hFFFC
`define EVPD_VEC_WDOG_RST 16'hFFFA

// ----------------------------------------------------------------------
// Low bytes of based vectors
// ----------------------------------------------------------------------
`define EVPD_LO_BASE 8'h00
`define EVPD_LO_TRAP 8'hF8
`define EVPD_LO_SWI 8'hF6
`define EVPD_LO_NONMASKABLE_PIN_REQUEST 8'hF4
`define EVPD_LO_IRQ 8'hF2
`define EVPD_LO_FIRST_MASKED 8'hF0
`define EVPD_LO_LAST_MASKED 8'h82
`define EVPD_LO_SPURIOUS 8'h80
`define EVPD_NUM_MASKED 56

// ----------------------------------------------------------------------
// Status register field positions
// ----------------------------------------------------------------------
`define EVPD_STAT_WAKE_BIT 16
`define EVPD_STAT_PEND_BIT 17

`endif

// >>> core/evpd_pkg.sv
// Types shared by the exception vector decoder
package evpd_pkg;

	// Non-maskable and single requests from the system
	typedef struct packed {
		logic rst_pin;
		logic rst_clkmon;
		logic rst_wdog;
		logic trap;
		logic software_interrupt;
		logic nonmaskable_pin_request;
		logic irq_pin;
	} evpd_req_t;

	// CPU flags seen by the decoder
	typedef struct packed {
		logic i_mask;
		logic x_mask;
		logic background_debug;
	} evpd_cpu_t;

endpackage

// >>> core/evpd_prio.sv
// Fixed priority encoder for the device specific maskable sources
`timescale 1ns/1ps
`include "evpd_consts.svh"

module evpd_prio
	import evpd_pkg::*;
#(
	parameter int N = `EVPD_NUM_MASKED
) (
	input wire logic [N-1:0] act_i,
	output logic hit_o,
	output logic [7:0] code_o
);

	// ------------------------------------------------------------------
	// Priority chain, entry 0 is the highest vector
	// ------------------------------------------------------------------
	logic [N:0] found;
	logic [7:0] code_chain [0:N];

	assign found[0] = 1'b0;
	assign code_chain[0] = `EVPD_LO_SPURIOUS;

	for (genvar k = 0; k < N; k++) begin : g_ent
		localparam logic [7:0] LO = 8'(`EVPD_LO_FIRST_MASKED - 2 * k);
		assign found[k+1] = found[k] | act_i[k];
		// Higher vector already found keeps its code
		assign code_chain[k+1] = (act_i[k] && !found[k]) ? LO : code_chain[k];
	end

	assign hit_o = found[N];
	assign code_o = code_chain[N];

endmodule

// >>> core/evpd_top.sv
// Exception request prioritizer and vector generator with bus registers
//
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`include "evpd_consts.svh"

module evpd_top
	import evpd_pkg::*;
#(
	parameter int N = `EVPD_NUM_MASKED
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [`EVPD_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Exception sources and CPU state
	input wire evpd_req_t req_i,
	input wire logic [N-1:0] src_req_i,
	input wire logic [N-1:0] src_en_i,
	input wire evpd_cpu_t cpu_condition_flags_i,
	// Vector port
	input wire logic vec_req_i,
	output logic [15:0] vec_o,
	output logic wake_o
);

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	logic [7:0] vector_base_byte_reg_r;
	logic [15:0] last_vec_r;
	logic ack_r;
	logic [31:0] rdat_r;

	// ------------------------------------------------------------------
	// Qualification
	// ------------------------------------------------------------------
	logic [7:0] vector_base_upper_bits;
	logic [15:0] vec_base;
	logic any_rst;
	logic x_act;
	logic higher_act;
	logic i_open;
	logic irq_act;
	logic [N-1:0] src_act;
	logic src_hit;
	logic [7:0] src_code;
	logic [7:0] lo_sel;
	logic any_act;
	logic [15:0] vec_sel;

	// Debug firmware must reach its own table at the top page
	assign vector_base_upper_bits = cpu_condition_flags_i.background_debug ?
		`EVPD_BASE_RST : vector_base_byte_reg_r;
	assign vec_base = {vector_base_upper_bits, `EVPD_LO_BASE};

	assign any_rst = req_i.rst_pin | req_i.rst_clkmon | req_i.rst_wdog;
	assign x_act = req_i.nonmaskable_pin_request &
		!cpu_condition_flags_i.x_mask;
	assign higher_act = req_i.trap | req_i.software_interrupt | x_act;
	assign i_open = !cpu_condition_flags_i.i_mask && !higher_act;
	assign irq_act = req_i.irq_pin & i_open;
	assign src_act = (src_req_i & src_en_i) & {N{i_open}};

	evpd_prio #(
		.N(N)
	) u_prio (
		.act_i(src_act),
		.hit_o(src_hit),
		.code_o(src_code)
	);

	assign any_act = any_rst | higher_act | irq_act | src_hit;

	// ------------------------------------------------------------------
	// Vector selection, evaluated live at the request
	// ------------------------------------------------------------------
	always_comb begin
		lo_sel = `EVPD_LO_SPURIOUS;
		if (req_i.trap) begin
			lo_sel = `EVPD_LO_TRAP;
		end else if (req_i.software_interrupt) begin
			lo_sel = `EVPD_LO_SWI;
		end else if (x_act) begin
			lo_sel = `EVPD_LO_NONMASKABLE_PIN_REQUEST;
		end else if (irq_act) begin
			lo_sel = `EVPD_LO_IRQ;
		end else if (src_hit) begin
			lo_sel = src_code;
		end
	end

	always_comb begin
		// Reset vectors ignore the base byte entirely
		if (req_i.rst_pin) begin
			vec_sel = `EVPD_VEC_PIN_RST;
		end else if (req_i.rst_clkmon) begin
			vec_sel = `EVPD_VEC_CLKMON_RST;
		end else if (req_i.rst_wdog) begin
			vec_sel = `EVPD_VEC_WDOG_RST;
		end else begin
			vec_sel = vec_base | {8'h00, lo_sel};
		end
	end

	assign vec_o = vec_sel;
	assign wake_o = |((src_req_i & src_en_i) &
		{N{!cpu_condition_flags_i.i_mask}}) |
		(req_i.irq_pin & !cpu_condition_flags_i.i_mask);

	// ------------------------------------------------------------------
	// Last supplied vector, readable for diagnosis
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			last_vec_r <= `EVPD_VEC_RST;
		end else if (ce_i && vec_req_i) begin
			last_vec_r <= vec_sel;
		end
	end

	// ------------------------------------------------------------------
	// Wishbone slave: ack one cycle after the strobe
	// ------------------------------------------------------------------
	logic bus_req;
	logic adr_base;
	logic adr_stat;

	assign bus_req = wb_cyc_i && wb_stb_i;
	assign adr_base = wb_adr_i == `EVPD_OFS_BASE;
	assign adr_stat = wb_adr_i == `EVPD_OFS_STAT;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else if (ce_i) begin
			ack_r <= bus_req && !ack_r;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdat_r <= 32'h0000_0000;
		end else if (ce_i && bus_req && !ack_r) begin
			rdat_r <= 32'h0000_0000;
			if (adr_base) begin
				rdat_r[7:0] <= vector_base_byte_reg_r;
			end else if (adr_stat) begin
				rdat_r[15:0] <= last_vec_r;
				rdat_r[`EVPD_STAT_WAKE_BIT] <= wake_o;
				rdat_r[`EVPD_STAT_PEND_BIT] <= any_act;
			end
		end
	end

	// Write lands on the edge where the master sees ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vector_base_byte_reg_r <= `EVPD_BASE_RST;
		end else if (ce_i && bus_req && ack_r && wb_we_i && adr_base &&
			wb_sel_i[0]) begin
			vector_base_byte_reg_r <= wb_dat_i[7:0];
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	chk_base_reset: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(rst_i) |-> vector_base_byte_reg_r == `EVPD_BASE_RST)
		else $error("base byte not 0xFF after reset");

	chk_pin_reset: assert property (@(posedge clk_i) disable iff (rst_i)
		vec_req_i && req_i.rst_pin |-> vec_o == `EVPD_VEC_PIN_RST)
		else $error("pin reset vector wrong");

	chk_reset_order: assert property (@(posedge clk_i) disable iff (rst_i)
		vec_req_i && !req_i.rst_pin && req_i.rst_clkmon |->
		vec_o == `EVPD_VEC_CLKMON_RST)
		else $error("clock monitor reset vector wrong");

	chk_debug_page: assert property (@(posedge clk_i) disable iff (rst_i)
		vec_req_i && cpu_condition_flags_i.background_debug |->
		vec_o[15:8] == `EVPD_BASE_RST)
		else $error("debug vector not in top page");

	chk_spurious_vec: assert property (@(posedge clk_i) disable iff (rst_i)
		vec_req_i && !any_act |->
		vec_o == {vector_base_upper_bits, `EVPD_LO_SPURIOUS})
		else $error("spurious vector wrong");

	chk_trap_vec: assert property (@(posedge clk_i) disable iff (rst_i)
		vec_req_i && !any_rst && req_i.trap |->
		vec_o == {vector_base_upper_bits, `EVPD_LO_TRAP})
		else $error("trap vector wrong");

	chk_x_outranks: assert property (@(posedge clk_i) disable iff (rst_i)
		vec_req_i && !any_rst && !req_i.trap && !req_i.software_interrupt &&
		x_act |-> vec_o[7:0] == `EVPD_LO_NONMASKABLE_PIN_REQUEST)
		else $error("X request lost to lower source");

	chk_mask_block: assert property (@(posedge clk_i) disable iff (rst_i)
		cpu_condition_flags_i.i_mask |-> !irq_act && src_act == '0)
		else $error("masked source passed with I flag set");

	chk_top_source: assert property (@(posedge clk_i) disable iff (rst_i)
		src_act[0] |-> src_code == `EVPD_LO_FIRST_MASKED)
		else $error("highest device source not chosen");

	chk_wake_src: assert property (@(posedge clk_i) disable iff (rst_i)
		src_req_i[0] && src_en_i[0] && !cpu_condition_flags_i.i_mask |->
		wake_o)
		else $error("qualified request does not wake");

	chk_last_vec: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && vec_req_i |=> last_vec_r == $past(vec_o))
		else $error("supplied vector not recorded");

	chk_base_write: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && bus_req && ack_r && wb_we_i && adr_base && wb_sel_i[0] |=>
		vector_base_byte_reg_r == $past(wb_dat_i[7:0]))
		else $error("base byte write not taken");

	chk_wdog_vec: assert property (@(posedge clk_i) disable iff (rst_i)
		vec_req_i && !req_i.rst_pin && !req_i.rst_clkmon && req_i.rst_wdog |->
		vec_o == `EVPD_VEC_WDOG_RST)
		else $error("watchdog reset vector wrong");

	chk_reset_fixed: assert property (@(posedge clk_i) disable iff (rst_i)
		vec_req_i && any_rst |-> vec_o[15:8] == `EVPD_BASE_RST)
		else $error("reset vector left the top page");

	chk_base_upper: assert property (@(posedge clk_i) disable iff (rst_i)
		vec_req_i && !any_rst && !cpu_condition_flags_i.background_debug |->
		vec_o[15:8] == vector_base_byte_reg_r)
		else $error("upper vector byte not the base byte");

	chk_swi_vec: assert property (@(posedge clk_i) disable iff (rst_i)
		vec_req_i && !any_rst && !req_i.trap && req_i.software_interrupt |->
		vec_o == {vector_base_upper_bits, `EVPD_LO_SWI})
		else $error("software interrupt vector wrong");

	chk_irq_vec: assert property (@(posedge clk_i) disable iff (rst_i)
		vec_req_i && !any_rst && irq_act |->
		vec_o == {vector_base_upper_bits, `EVPD_LO_IRQ})
		else $error("external pin vector wrong");

	chk_masked_below: assert property (@(posedge clk_i) disable iff (rst_i)
		vec_req_i && !any_rst && higher_act |->
		vec_o[7:0] >= `EVPD_LO_NONMASKABLE_PIN_REQUEST)
		else $error("masked source beat a higher request");

	chk_higher_block: assert property (@(posedge clk_i) disable iff (rst_i)
		higher_act |-> !irq_act && src_act == '0)
		else $error("masked source passed a higher request");

	chk_low_source: assert property (@(posedge clk_i) disable iff (rst_i)
		src_act == {1'b1, {(N-1){1'b0}}} |->
		src_code == `EVPD_LO_LAST_MASKED)
		else $error("lowest device source vector wrong");

	chk_late_winner: assert property (@(posedge clk_i) disable iff (rst_i)
		vec_req_i && !any_rst && $rose(req_i.trap) |->
		vec_o[7:0] == `EVPD_LO_TRAP)
		else $error("late trap not chosen");

	chk_wake_mask: assert property (@(posedge clk_i) disable iff (rst_i)
		cpu_condition_flags_i.i_mask |-> !wake_o)
		else $error("wake with I flag set");

	chk_last_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!ce_i |=> $stable(last_vec_r))
		else $error("recorded vector moved while frozen");

endmodule

// >>> bench/evpd_cpu_model.sv
// CPU side model that strobes vector requests and keeps the vector
`timescale 1ns/1ps

module evpd_cpu_model (
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [15:0] vec_i,
	output logic vec_req_o,
	output logic [15:0] got_o
);
	initial begin
		vec_req_o = 1'b0;
		got_o = 16'h0000;
	end

	// One-cycle strobe; the vector is taken at the edge that samples it
	always @(posedge clk_i) begin
		vec_req_o <= go_i;
		if (vec_req_o) begin
			got_o <= vec_i;
		end
	end
endmodule

// >>> bench/testbench.sv
// Self-checking bench for the exception vector decoder
`timescale 1ns/1ps

module testbench;
	import evpd_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h00000000;
	logic [31:0] dat_o;
	logic [31:0] q;
	logic ack;
	logic go = 1'b0;
	logic ce = 1'b1;
	logic vreq_s;
	logic wake;
	evpd_req_t req = 7'h00;
	evpd_cpu_t flags = 3'h0;
	logic [55:0] src = 56'h0;
	logic [55:0] en = 56'h0;
	logic [15:0] vec;
	logic [15:0] got;
	logic [33:0] rw;
	logic [31:0] gv;
	logic [31:0] ev;
	int err_count = 0;
	int total_checks = 0;
	// Rows: requests, cpu flags, source index (FF none), vector; base 12
	logic [33:0] rows [0:13] = '{
		{7'h7F, 3'h0, 8'hFF, 16'hFFFE}, {7'h3F, 3'h0, 8'hFF, 16'hFFFC},
		{7'h1F, 3'h0, 8'hFF, 16'hFFFA}, {7'h0F, 3'h4, 8'h00, 16'h12F8},
		{7'h07, 3'h0, 8'h00, 16'h12F6}, {7'h03, 3'h0, 8'h00, 16'h12F4},
		{7'h03, 3'h2, 8'h00, 16'h12F2}, {7'h01, 3'h0, 8'h00, 16'h12F2},
		{7'h00, 3'h0, 8'h00, 16'h12F0}, {7'h00, 3'h0, 8'h37, 16'h1282},
		{7'h00, 3'h4, 8'h03, 16'h1280}, {7'h00, 3'h0, 8'hFF, 16'h1280},
		{7'h01, 3'h1, 8'hFF, 16'hFFF2}, {7'h02, 3'h2, 8'hFF, 16'h1280}};

	always #50 clk_i = ~clk_i;

	evpd_top evpd_top_inst (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.req_i(req), .src_req_i(src), .src_en_i(en),
		.cpu_condition_flags_i(flags), .vec_req_i(vreq_s), .vec_o(vec),
		.wake_o(wake));

	evpd_cpu_model evpd_cpu_model_inst (
		.clk_i(clk_i), .go_i(go), .vec_i(vec), .vec_req_o(vreq_s),
		.got_o(got));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task finish_test;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task wb(input logic w, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] r);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 40);
		if (ack !== 1'b1) begin
			err_count++;
			finish_test;
		end
		r = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	// Sources stay put until the vector has been taken
	task vreq(input logic [6:0] r, input logic [2:0] c,
		input logic [55:0] s, input logic [55:0] e);
		@(posedge clk_i);
		req <= r;
		flags <= c;
		src <= s;
		en <= e;
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		@(posedge clk_i);
		@(negedge clk_i);
	endtask

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, 4'h0, 32'h0, 4'hF, q);
		chk("base reset", q, 32'h000000FF);
		wb(1'b1, 4'h0, 32'h00000012, 4'h1, q);
		wb(1'b1, 4'h0, 32'h00000034, 4'hE, q);
		wb(1'b0, 4'h0, 32'h0, 4'hF, q);
		chk("base", q, 32'h00000012);
		wb(1'b0, 4'h8, 32'h0, 4'hF, q);
		chk("unmapped", q, 32'h00000000);
		foreach (rows[i]) begin
			rw = rows[i];
			vreq(rw[33:27], rw[26:24],
				(rw[23:16] == 8'hFF) ? 56'h0 : (56'h1 << rw[23:16]),
				{56{1'b1}});
			gv = {24'h000000, got[15:8]};
			ev = {24'h000000, rw[15:8]};
			chk("vector high", gv, ev);
			gv = {24'h000000, got[7:0]};
			ev = {24'h000000, rw[7:0]};
			chk("vector low", gv, ev);
			chk("wake", {31'h0, wake},
				{31'h0, ~rw[26] & (rw[27] | (rw[23:16] != 8'hFF))});
		end
		vreq(7'h00, 3'h0, 56'h220, {56{1'b1}});
		chk("two sources", {16'h0000, got}, 32'h000012E6);
		vreq(7'h00, 3'h0, 56'h8, 56'h0);
		chk("disabled", {16'h0000, got}, 32'h00001280);
		chk("wake off", {31'h0, wake}, 32'h0);
		@(posedge clk_i);
		req <= 7'h00;
		src <= 56'h80;
		en <= {56{1'b1}};
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		req <= 7'h08;
		@(posedge clk_i);
		@(negedge clk_i);
		chk("late trap", {16'h0000, got}, 32'h000012F8);
		wb(1'b0, 4'h4, 32'h0, 4'hF, q);
		chk("status", {16'h0000, q[15:0]}, 32'h000012F8);
		chk("status flags", {30'h0, q[17:16]}, 32'h00000003);
		// Frozen core keeps its record but still answers the vector
		ce <= 1'b0;
		vreq(7'h04, 3'h0, 56'h0, 56'h0);
		chk("frozen vector", {16'h0000, got}, 32'h000012F6);
		@(posedge clk_i);
		ce <= 1'b1;
		wb(1'b0, 4'h4, 32'h0, 4'hF, q);
		chk("frozen status", q, 32'h000212F8);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, 4'h0, 32'h0, 4'hF, q);
		chk("base rereset", q, 32'h000000FF);
		wb(1'b0, 4'h4, 32'h0, 4'hF, q);
		chk("status rereset", q, 32'h00020000);
		finish_test;
	end
endmodule
